/* verilog/dtm_pkg.sv */
// constants for the die temperature monitor
// Functional notes
// - converter clock is sample clock divided by eight times the divider setting.
// - three modes: single shot, repeated, repeated with sticky alarm.
// - repeated modes start a conversion each time the interval count elapses.
// - every completed reading is compared against the programmed threshold.
// - reading above threshold sets alarm flag and asserts mute request.
// - in alarm mode the flag stays set after readings fall back.
// - held alarm clears only on the alarm-clear command bit.
// - highest and lowest registers track new extremes of readings.
// - every completed reading is stored in the present-reading register.
// - highest and lowest registers clear independently on their own command bits.
// - all reading registers hold the raw converter code, unscaled.
package dtm_pkg;
    localparam int DTM_CODE_W = 6;
    localparam int DTM_DIV_W = 8;
    localparam int DTM_INTV_W = 16;
    localparam int DTM_PRE_DIV = 8;
    localparam logic [DTM_CODE_W-1:0] DTM_HIGH_RST = 6'h00;
    localparam logic [DTM_CODE_W-1:0] DTM_LOW_RST = 6'h3F;
    localparam logic [1:0] DTM_MODE_SINGLE = 2'h0;
    localparam logic [1:0] DTM_MODE_REPEAT = 2'h1;
    localparam logic [1:0] DTM_MODE_ALARM = 2'h2;
    typedef enum logic [1:0]
    {
        DTM_IDLE = 2'b00,
        DTM_CONV = 2'b01,
        DTM_WAIT = 2'b10
    } dtm_state_e;
endpackage : dtm_pkg

/* verilog/dtm_clk_div.sv */
// sensor clock tick generator
`timescale 1ns/100ps
module dtm_clk_div
    import dtm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [DTM_DIV_W-1:0] div_setting,
    output logic tick
);
    logic [DTM_DIV_W+2:0] cnt_reg;
    logic [DTM_DIV_W+2:0] limit;

    // period is eight times the setting, setting 0 treated as 1
    assign limit = (div_setting == '0) ? (DTM_DIV_W+3)'(DTM_PRE_DIV)
        : (DTM_DIV_W+3)'(DTM_PRE_DIV) * {3'h0, div_setting};

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end
        else if (cnt_reg >= limit - (DTM_DIV_W+3)'(1))
        begin
            cnt_reg <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + (DTM_DIV_W+3)'(1);
            tick <= 1'b0;
        end
    end
endmodule : dtm_clk_div

/* verilog/dtm_top.sv */
// die temperature monitor control and readout
`timescale 1ns/100ps
module dtm_top
    import dtm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [1:0] measure_mode,
    input wire logic [DTM_DIV_W-1:0] sensor_clk_div,
    input wire logic [DTM_INTV_W-1:0] measure_interval_count,
    input wire logic [DTM_CODE_W-1:0] over_heat_threshold,
    input wire logic start_cmd,
    input wire logic clear_heat_flag_cmd,
    input wire logic clear_highest_cmd,
    input wire logic clear_lowest_cmd,
    input wire logic [DTM_CODE_W-1:0] conv_code,
    input wire logic conv_done,
    output logic conv_start,
    output logic conv_clk_tick,
    output logic [DTM_CODE_W-1:0] present_reading,
    output logic [DTM_CODE_W-1:0] highest_reading,
    output logic [DTM_CODE_W-1:0] lowest_reading,
    output logic heat_alarm,
    output logic mute_req,
    output logic busy
);
    // ==========================================================
    // input synchronisers (converter side is asynchronous)
    logic [DTM_CODE_W-1:0] code_s1_reg;
    logic [DTM_CODE_W-1:0] code_s2_reg;
    logic done_s1_reg;
    logic done_s2_reg;
    logic done_s3_reg;
    logic done_pulse;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            code_s1_reg <= '0;
            code_s2_reg <= '0;
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_s3_reg <= 1'b0;
        end
        else
        begin
            code_s1_reg <= conv_code;
            code_s2_reg <= code_s1_reg;
            done_s1_reg <= conv_done;
            done_s2_reg <= done_s1_reg;
            done_s3_reg <= done_s2_reg;
        end
    end

    // code is stable while done is high, so capture on the done edge
    assign done_pulse = done_s2_reg & ~done_s3_reg;

    // ==========================================================
    // sensor clock
    logic tick;

    dtm_clk_div u_div
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .div_setting(sensor_clk_div),
        .tick(tick)
    );

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            conv_clk_tick <= 1'b0;
        else
            conv_clk_tick <= tick;
    end

    // ==========================================================
    // measurement sequencer
    dtm_state_e state_reg;
    logic [DTM_INTV_W-1:0] intv_reg;
    logic repeat_mode;
    logic interval_done;

    assign repeat_mode = (measure_mode == DTM_MODE_REPEAT)
        || (measure_mode == DTM_MODE_ALARM);
    // the tick that completes the interval launches the next conversion
    assign interval_done = tick && (({1'b0, intv_reg} + (DTM_INTV_W+1)'(1))
        >= {1'b0, measure_interval_count});

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= DTM_IDLE;
            conv_start <= 1'b0;
        end
        else
        begin
            conv_start <= 1'b0;
            case (state_reg)
                DTM_IDLE:
                begin
                    // one conversion per request in single mode
                    if ((measure_mode == DTM_MODE_SINGLE && start_cmd)
                        || (repeat_mode && start_cmd))
                    begin
                        state_reg <= DTM_CONV;
                        conv_start <= 1'b1;
                    end
                end
                DTM_CONV:
                begin
                    if (done_pulse)
                        state_reg <= repeat_mode ? DTM_WAIT : DTM_IDLE;
                end
                DTM_WAIT:
                begin
                    if (!repeat_mode)
                        state_reg <= DTM_IDLE;
                    else if (interval_done)
                    begin
                        state_reg <= DTM_CONV;
                        conv_start <= 1'b1;
                    end
                end
                default:
                    state_reg <= DTM_IDLE;
            endcase
        end
    end

    // interval counted in sensor clock cycles from the previous start
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            intv_reg <= '0;
        else if (conv_start)
            intv_reg <= '0;
        else if (tick && intv_reg != '1)
            intv_reg <= intv_reg + DTM_INTV_W'(1);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            busy <= 1'b0;
        else
            busy <= (state_reg != DTM_IDLE);
    end

    // ==========================================================
    // readings, raw codes only
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            present_reading <= '0;
        else if (done_pulse)
            present_reading <= code_s2_reg;
    end

    // a new reading wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            highest_reading <= DTM_HIGH_RST;
        else if (done_pulse && clear_highest_cmd)
            highest_reading <= code_s2_reg;
        else if (done_pulse && code_s2_reg > highest_reading)
            highest_reading <= code_s2_reg;
        else if (clear_highest_cmd)
            highest_reading <= DTM_HIGH_RST;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            lowest_reading <= DTM_LOW_RST;
        else if (done_pulse && clear_lowest_cmd)
            lowest_reading <= code_s2_reg;
        else if (done_pulse && code_s2_reg < lowest_reading)
            lowest_reading <= code_s2_reg;
        else if (clear_lowest_cmd)
            lowest_reading <= DTM_LOW_RST;
    end

    // ==========================================================
    // over-temperature alarm and mute
    logic over;

    assign over = done_pulse && (code_s2_reg > over_heat_threshold);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            heat_alarm <= 1'b0;
        else if (over)
            heat_alarm <= 1'b1;
        else if (measure_mode == DTM_MODE_ALARM)
        begin
            if (clear_heat_flag_cmd)
                heat_alarm <= 1'b0;
        end
        else if (done_pulse || clear_heat_flag_cmd)
            heat_alarm <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            mute_req <= 1'b0;
        else if (over)
            mute_req <= 1'b1;
        else if (measure_mode == DTM_MODE_ALARM)
        begin
            if (clear_heat_flag_cmd)
                mute_req <= 1'b0;
        end
        else if (done_pulse || clear_heat_flag_cmd)
            mute_req <= 1'b0;
    end
endmodule : dtm_top

/* tb/dtm_properties.sv */
// port-level checks of the die temperature monitor
`timescale 1ns/100ps
module dtm_properties
    import dtm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [1:0] measure_mode,
    input wire logic [DTM_CODE_W-1:0] over_heat_threshold,
    input wire logic start_cmd,
    input wire logic clear_heat_flag_cmd,
    input wire logic clear_highest_cmd,
    input wire logic clear_lowest_cmd,
    input wire logic conv_done,
    input wire logic conv_start,
    input wire logic conv_clk_tick,
    input wire logic [DTM_CODE_W-1:0] present_reading,
    input wire logic [DTM_CODE_W-1:0] highest_reading,
    input wire logic [DTM_CODE_W-1:0] lowest_reading,
    input wire logic heat_alarm,
    input wire logic mute_req
);
    // cycles since converter done was high; clears only judged when quiet
    logic [2:0] quiet_reg;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            quiet_reg <= 3'h0;
        else if (conv_done)
            quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7)
            quiet_reg <= quiet_reg + 3'h1;
    end
    // ==========================================================
    // assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_mute_follows_alarm: assert property (mute_req == heat_alarm)
        else $error("mute request differs from alarm");
    a_single_needs_start: assert property (conv_start &&
        measure_mode == DTM_MODE_SINGLE |-> $past(start_cmd))
        else $error("conversion started without request");
    a_tick_spacing: assert property (conv_clk_tick |=> !conv_clk_tick [*7])
        else $error("converter tick too close");
    a_high_clears: assert property (clear_highest_cmd &&
        quiet_reg > 3'h4 |=> highest_reading == DTM_HIGH_RST)
        else $error("highest not cleared");
    a_low_clears: assert property (clear_lowest_cmd &&
        quiet_reg > 3'h4 |=> lowest_reading == DTM_LOW_RST)
        else $error("lowest not cleared");
    a_high_only_grows: assert property (!clear_highest_cmd |=>
        highest_reading >= $past(highest_reading))
        else $error("highest fell");
    a_extremes_bound_reading: assert property ($changed(present_reading) |->
        highest_reading >= present_reading && lowest_reading <= present_reading)
        else $error("extremes miss reading");
    a_exceed_sets_alarm: assert property ($changed(present_reading) &&
        present_reading > over_heat_threshold |-> heat_alarm)
        else $error("alarm missing on hot reading");
    a_alarm_held: assert property (measure_mode == DTM_MODE_ALARM &&
        heat_alarm && !clear_heat_flag_cmd |=> heat_alarm)
        else $error("held alarm dropped");
    cover property (heat_alarm && measure_mode == DTM_MODE_ALARM);
    cover property (conv_start && measure_mode == DTM_MODE_REPEAT);
    cover property (clear_highest_cmd && quiet_reg > 3'h4);
endmodule : dtm_properties

/* tb/dtm_top_tb.sv */
// self-checking bench for the die temperature monitor
`timescale 1ns/100ps
module dtm_top_tb
    import dtm_pkg::*;
;
    logic sys_clk = 1'b0, rstn = 1'b0, start_cmd = 1'b0, conv_done = 1'b0;
    logic clear_heat_flag_cmd = 1'b0, clear_highest_cmd = 1'b0;
    logic clear_lowest_cmd = 1'b0;
    logic [1:0] measure_mode = 2'h0;
    logic [DTM_DIV_W-1:0] sensor_clk_div = 8'h02;
    logic [DTM_INTV_W-1:0] measure_interval_count = 16'h0003;
    logic [DTM_CODE_W-1:0] over_heat_threshold = 6'h25, conv_code = 6'h00;
    logic [DTM_CODE_W-1:0] present_reading, highest_reading, lowest_reading;
    logic conv_start, conv_clk_tick, heat_alarm, mute_req, busy;
    logic [DTM_CODE_W-1:0] code_q [$];
    int fails = 0, comparisons = 0, cyc = 0, starts = 0, last_s = 0, gap = 0;
    int last_t = 0, tgap = 0;
    dtm_top dut (.sys_clk, .rstn, .measure_mode, .sensor_clk_div,
        .measure_interval_count, .over_heat_threshold, .start_cmd,
        .clear_heat_flag_cmd, .clear_highest_cmd, .clear_lowest_cmd,
        .conv_code, .conv_done, .conv_start, .conv_clk_tick, .present_reading,
        .highest_reading, .lowest_reading, .heat_alarm, .mute_req, .busy);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (conv_start === 1'b1)
        begin
            gap = cyc - last_s;
            last_s = cyc;
            starts++;
        end
        if (conv_clk_tick === 1'b1)
        begin
            tgap = cyc - last_t;
            last_t = cyc;
        end
        if (cyc == 3000)
        begin
            fails++;
            final_report;
        end
    end
    // ==========================================================
    // converter stand-in: code scrambled once done falls
    initial forever
    begin
        @(negedge sys_clk);
        if (conv_start === 1'b1)
        begin
            repeat (3) @(negedge sys_clk);
            conv_code = code_q.size() ? code_q.pop_front() : 6'h15;
            conv_done = 1'b1;
            repeat (4) @(negedge sys_clk);
            conv_done = 1'b0;
            conv_code = ~conv_code;
        end
    end
    task automatic check(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic do_reset(logic [1:0] m);
        rstn = 1'b0;
        wait (conv_done === 1'b0);
        measure_mode = m;
        repeat (5) @(negedge sys_clk);
        starts = 0;
        rstn = 1'b1;
    endtask : do_reset
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask : pulse
    task automatic wait_rd(logic [5:0] v);
        int n;
        n = 0;
        while (present_reading !== v && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        repeat (2) @(negedge sys_clk);
        check("present", v, present_reading);
    endtask : wait_rd
    task automatic meas(logic [5:0] v, logic [5:0] hi, logic [5:0] lo);
        code_q.push_back(v);
        pulse(start_cmd);
        wait_rd(v);
        check("highest", hi, highest_reading);
        check("lowest", lo, lowest_reading);
    endtask : meas
    task automatic s_single;
        do_reset(DTM_MODE_SINGLE);
        check("lowest", DTM_LOW_RST, lowest_reading);
        meas(6'h10, 6'h10, 6'h10);
        meas(6'h08, 6'h10, 6'h08);
        meas(6'h26, 6'h26, 6'h08);
        check("alarm", 1, heat_alarm);
        check("mute", 1, mute_req);
        meas(6'h25, 6'h26, 6'h08);
        check("alarm", 0, heat_alarm);
        repeat (60) @(negedge sys_clk);
        check("starts", 4, 16'(starts));
        check("busy", 0, busy);
        check("tick period", 16'h0010, 16'(tgap));
        pulse(clear_highest_cmd);
        check("highest", DTM_HIGH_RST, highest_reading);
        check("lowest", 6'h08, lowest_reading);
        pulse(clear_lowest_cmd);
        check("lowest", DTM_LOW_RST, lowest_reading);
    endtask : s_single
    task automatic s_repeat(logic [1:0] m);
        do_reset(m);
        code_q = '{6'h30, 6'h05};
        pulse(start_cmd);
        wait_rd(6'h30);
        check("alarm", 1, heat_alarm);
        check("busy", 1, busy);
        wait_rd(6'h05);
        check("alarm", m == DTM_MODE_ALARM, heat_alarm);
        pulse(clear_heat_flag_cmd);
        check("alarm", 0, heat_alarm);
        wait_rd(6'h15);
        check("gap", 16'd48, 16'(gap));
    endtask : s_repeat
    initial
    begin
        s_single;
        s_repeat(DTM_MODE_REPEAT);
        s_repeat(DTM_MODE_ALARM);
        final_report;
    end
endmodule : dtm_top_tb
bind dtm_top dtm_properties u_props (.sys_clk, .rstn, .measure_mode,
    .over_heat_threshold, .start_cmd, .clear_heat_flag_cmd,
    .clear_highest_cmd, .clear_lowest_cmd, .conv_done, .conv_start,
    .conv_clk_tick, .present_reading, .highest_reading, .lowest_reading,
    .heat_alarm, .mute_req);
